// ===== dsl_pkg.sv
// Constants and carrier types for the down-converter and link config bank
// Assumes a 32-bit Avalon-MM slave port with byte addressing

package dsl_pkg;

  // ************************************************************
  // Register indices and address width
  // ************************************************************
  localparam logic [9:0]  IDX_DDC_CTRL  = 10'h200;
  localparam logic [9:0]  IDX_LINK_CTL1 = 10'h201;
  localparam logic [9:0]  IDX_LINK_CTL2 = 10'h202;
  localparam logic [9:0]  IDX_LINK_ID   = 10'h203;
  localparam int          ADDR_W        = 12;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0]  RST_DDC_CTRL  = 8'h10;
  localparam logic [7:0]  RST_LINK_CTL1 = 8'h0f;
  localparam logic [7:0]  RST_LINK_CTL2 = 8'h00;
  localparam logic [7:0]  RST_LINK_ID   = 8'h00;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int          DDC_FMT_BIT   = 5;
  localparam int          DDC_GAIN_BIT  = 4;
  localparam int          DDC_SEL_LSB   = 0;
  localparam int          DDC_SEL_W     = 4;
  localparam int          CTL1_SCRM_BIT = 7;
  localparam int          CTL1_K_LSB    = 2;
  localparam int          CTL1_K_W      = 5;
  localparam int          CTL1_RATE_BIT = 1;
  localparam int          CTL1_EN_BIT   = 0;
  localparam int          CTL2_PLL_BIT  = 7;
  localparam int          CTL2_SYNC_BIT = 6;
  localparam int          CTL2_TEST_LSB = 0;
  localparam int          CTL2_TEST_W   = 4;

  // ************************************************************
  // Decimation, test pattern and identifier slot codes
  // ************************************************************
  localparam logic [3:0]  DEC_BYPASS    = 4'h0;
  localparam logic [3:0]  DEC_BY4       = 4'h2;
  localparam logic [3:0]  DEC_BY8       = 4'h3;
  localparam logic [3:0]  DEC_BY10      = 4'h4;
  localparam logic [3:0]  DEC_BY16      = 4'h5;
  localparam logic [3:0]  DEC_BY20      = 4'h6;
  localparam logic [3:0]  DEC_BY32      = 4'h7;
  localparam logic [3:0]  TEST_PRBS7    = 4'h1;
  localparam logic [1:0]  MF_ID_SLOT    = 2'h2;

  // ************************************************************
  // Carrier types
  // ************************************************************
  typedef struct packed {
    logic       ddc_on;
    logic       reserved;
    logic       twos;
    logic [5:0] factor;
  } dsl_ddc_s;

  typedef enum logic {BUS_IDLE, BUS_ACK} dsl_bus_e;

endpackage

// ===== dsl_ddc_decode.sv
// Registered decoder of the decimation select and sample format fields
// Assumes CLOCK and ARST_N shared with the register bank

`timescale 1ns/100ps

module dsl_ddc_decode (
  input  wire logic           CLOCK,
  input  wire logic           ARST_N,
  input  wire logic [3:0]     SEL,
  input  wire logic           BYPASS_TWOS,
  output dsl_pkg::dsl_ddc_s   DDC
);

  // ************************************************************
  // Decode
  // ************************************************************
  dsl_pkg::dsl_ddc_s ddc_d;
  dsl_pkg::dsl_ddc_s ddc_q;

  always_comb begin
    ddc_d.ddc_on   = 1'b1;
    ddc_d.reserved = 1'b0;
    ddc_d.twos     = 1'b1;
    ddc_d.factor   = 6'h01;
    unique case (SEL)
      dsl_pkg::DEC_BYPASS: begin
        ddc_d.ddc_on = 1'b0;
        ddc_d.twos   = BYPASS_TWOS;
      end
      dsl_pkg::DEC_BY4:  ddc_d.factor = 6'h04;
      dsl_pkg::DEC_BY8:  ddc_d.factor = 6'h08;
      dsl_pkg::DEC_BY10: ddc_d.factor = 6'h0a;
      dsl_pkg::DEC_BY16: ddc_d.factor = 6'h10;
      dsl_pkg::DEC_BY20: ddc_d.factor = 6'h14;
      dsl_pkg::DEC_BY32: ddc_d.factor = 6'h20;
      default: begin
        // Reserved codes park the converter in bypass, flagged
        ddc_d.ddc_on   = 1'b0;
        ddc_d.reserved = 1'b1;
        ddc_d.twos     = BYPASS_TWOS;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ddc_q <= '{ddc_on: 1'b0, reserved: 1'b0, twos: 1'b0,
                 factor: 6'h01};
    end else begin
      ddc_q <= ddc_d;
    end
  end

  assign DDC = ddc_q;

endmodule

// ===== dsl_config_bank.sv
// Configuration bank for the down-converter and the serial data link
// Assumes an Avalon-MM master with waitrequest on CLOCK, byte addresses
//
// Chosen here: the Avalon-MM interface to the registers.

`timescale 1ns/100ps

module dsl_config_bank (
  input  wire logic        CLOCK,
  input  wire logic        ARST_N,
  input  wire logic [11:0] AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        SYNC_SE_N,
  input  wire logic        SYNC_DIFF_N,
  input  wire logic        LINK_MF_START,
  output logic             LINK_RESET_N,
  output logic             SERDES_POWER_DOWN,
  output logic             LINK_CLOCK_ENABLE,
  output logic             SYNC_REQUEST_N,
  output logic             SCRAMBLER_ENABLE,
  output logic      [5:0]  FRAMES_PER_MULTIFRAME,
  output logic             LANE_RATE_DOUBLE,
  output logic             FIVE_FOURTHS_PLL_SELECT,
  output logic      [3:0]  LINK_TEST_PATTERN,
  output logic             LINK_PRBS7_ACTIVE,
  output logic      [7:0]  LINK_DEVICE_IDENTIFIER,
  output logic             LINK_DID_INSERT,
  output logic             DDC_ENABLE,
  output logic      [5:0]  DECIMATION_FACTOR,
  output logic             DECIMATION_RESERVED,
  output logic             SAMPLE_TWOS_COMPLEMENT,
  output logic             FINAL_FILTER_GAIN_BOOST
);

  // ************************************************************
  // Bus slave
  // ************************************************************
  dsl_pkg::dsl_bus_e bus_q;
  logic [9:0]        word_idx;
  logic              req;
  logic              hit;
  logic              wr_take;
  logic [7:0]        rd_mux;
  logic [31:0]       rdata_q;

  assign word_idx = AVS_ADDRESS[11:2];
  assign req      = AVS_READ | AVS_WRITE;
  // One wait cycle per access; the answer edge follows the ack state
  assign AVS_WAITREQUEST = req & (bus_q == dsl_pkg::BUS_IDLE);
  assign wr_take  = AVS_WRITE & (bus_q == dsl_pkg::BUS_ACK)
                  & AVS_BYTEENABLE[0];
  assign AVS_READDATA = rdata_q;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      bus_q <= dsl_pkg::BUS_IDLE;
    end else begin
      unique case (bus_q)
        dsl_pkg::BUS_IDLE: begin
          if (req) begin
            bus_q <= dsl_pkg::BUS_ACK;
          end
        end
        dsl_pkg::BUS_ACK: bus_q <= dsl_pkg::BUS_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Register file
  // ************************************************************
  logic [7:0] ddc_ctrl_q;
  logic [7:0] link_ctl1_q;
  logic [7:0] link_ctl2_q;
  logic [7:0] link_id_q;

  // Reserved bits are stored like any other and drive nothing
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ddc_ctrl_q  <= dsl_pkg::RST_DDC_CTRL;
      link_ctl1_q <= dsl_pkg::RST_LINK_CTL1;
      link_ctl2_q <= dsl_pkg::RST_LINK_CTL2;
      link_id_q   <= dsl_pkg::RST_LINK_ID;
    end else if (wr_take) begin
      unique case (word_idx)
        dsl_pkg::IDX_DDC_CTRL:  ddc_ctrl_q  <= AVS_WRITEDATA[7:0];
        dsl_pkg::IDX_LINK_CTL1: link_ctl1_q <= AVS_WRITEDATA[7:0];
        dsl_pkg::IDX_LINK_CTL2: link_ctl2_q <= AVS_WRITEDATA[7:0];
        dsl_pkg::IDX_LINK_ID:   link_id_q   <= AVS_WRITEDATA[7:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    hit    = 1'b1;
    rd_mux = 8'h00;
    unique case (word_idx)
      dsl_pkg::IDX_DDC_CTRL:  rd_mux = ddc_ctrl_q;
      dsl_pkg::IDX_LINK_CTL1: rd_mux = link_ctl1_q;
      dsl_pkg::IDX_LINK_CTL2: rd_mux = link_ctl2_q;
      dsl_pkg::IDX_LINK_ID:   rd_mux = link_id_q;
      default:                hit    = 1'b0;
    endcase
  end

  // Unmapped reads answer zero; upper lanes always read zero
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_q <= 32'h0000_0000;
    end else if (AVS_READ && bus_q == dsl_pkg::BUS_IDLE) begin
      rdata_q <= {24'h00_0000, rd_mux};
    end
  end

  // ************************************************************
  // Field extraction
  // ************************************************************
  logic       link_en;
  logic [3:0] dec_sel;
  logic [4:0] k_minus_1;

  assign link_en   = link_ctl1_q[dsl_pkg::CTL1_EN_BIT];
  assign dec_sel   = ddc_ctrl_q[dsl_pkg::DDC_SEL_LSB +: dsl_pkg::DDC_SEL_W];
  assign k_minus_1 = link_ctl1_q[dsl_pkg::CTL1_K_LSB +: dsl_pkg::CTL1_K_W];

  // ************************************************************
  // Down-converter controls
  // ************************************************************
  dsl_pkg::dsl_ddc_s ddc;

  dsl_ddc_decode u_decode (
    .CLOCK       (CLOCK),
    .ARST_N      (ARST_N),
    .SEL         (dec_sel),
    .BYPASS_TWOS (ddc_ctrl_q[dsl_pkg::DDC_FMT_BIT]),
    .DDC         (ddc)
  );

  assign DDC_ENABLE             = ddc.ddc_on;
  assign DECIMATION_FACTOR      = ddc.factor;
  assign DECIMATION_RESERVED    = ddc.reserved;
  assign SAMPLE_TWOS_COMPLEMENT = ddc.twos;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      FINAL_FILTER_GAIN_BOOST <= 1'b1;
    end else begin
      FINAL_FILTER_GAIN_BOOST <= ddc_ctrl_q[dsl_pkg::DDC_GAIN_BIT];
    end
  end

  // ************************************************************
  // Link controls
  // ************************************************************
  // The link consumes these only out of reset, so the software ordering
  // around the enable bit keeps it from seeing half-changed settings
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      LINK_RESET_N            <= 1'b0;
      SERDES_POWER_DOWN       <= 1'b1;
      LINK_CLOCK_ENABLE       <= 1'b0;
      SCRAMBLER_ENABLE        <= 1'b0;
      FRAMES_PER_MULTIFRAME   <= 6'h04;
      LANE_RATE_DOUBLE        <= 1'b1;
      FIVE_FOURTHS_PLL_SELECT <= 1'b0;
      LINK_TEST_PATTERN       <= 4'h0;
      LINK_PRBS7_ACTIVE       <= 1'b0;
      LINK_DEVICE_IDENTIFIER  <= 8'h00;
    end else begin
      LINK_RESET_N      <= link_en;
      SERDES_POWER_DOWN <= !link_en;
      LINK_CLOCK_ENABLE <= link_en;
      SCRAMBLER_ENABLE  <= link_ctl1_q[dsl_pkg::CTL1_SCRM_BIT];
      FRAMES_PER_MULTIFRAME <= {1'b0, k_minus_1} + 6'h01;
      LANE_RATE_DOUBLE  <= link_ctl1_q[dsl_pkg::CTL1_RATE_BIT];
      FIVE_FOURTHS_PLL_SELECT <= link_ctl2_q[dsl_pkg::CTL2_PLL_BIT];
      LINK_TEST_PATTERN <=
        link_ctl2_q[dsl_pkg::CTL2_TEST_LSB +: dsl_pkg::CTL2_TEST_W];
      LINK_PRBS7_ACTIVE <=
        link_ctl2_q[dsl_pkg::CTL2_TEST_LSB +: dsl_pkg::CTL2_TEST_W]
        == dsl_pkg::TEST_PRBS7;
      LINK_DEVICE_IDENTIFIER <= link_id_q;
    end
  end

  // ************************************************************
  // Sync input selection
  // ************************************************************
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      SYNC_REQUEST_N <= 1'b1;
    end else begin
      SYNC_REQUEST_N <= link_ctl2_q[dsl_pkg::CTL2_SYNC_BIT] ?
                        SYNC_DIFF_N : SYNC_SE_N;
    end
  end

  // ************************************************************
  // Identifier slot in lane alignment
  // ************************************************************
  // Counts multiframe starts since enable; saturates so that a long
  // alignment sequence never wraps back into the identifier slot
  // Clearing on the enable bit too stops the slot outliving the link
  logic [1:0] mf_count_q;
  logic [1:0] mf_count_d;

  always_comb begin
    mf_count_d = mf_count_q;
    if (LINK_MF_START && mf_count_q != 2'h3) begin
      mf_count_d = mf_count_q + 2'h1;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      mf_count_q      <= 2'h0;
      LINK_DID_INSERT <= 1'b0;
    end else if (!LINK_RESET_N || !link_en) begin
      mf_count_q      <= 2'h0;
      LINK_DID_INSERT <= 1'b0;
    end else begin
      mf_count_q      <= mf_count_d;
      LINK_DID_INSERT <= mf_count_d == dsl_pkg::MF_ID_SLOT;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);

  a_first_cycle_waits: assert property (
    req && bus_q == dsl_pkg::BUS_IDLE |-> AVS_WAITREQUEST ##1
    (!req || !AVS_WAITREQUEST))
    else $error("access not answered after one wait cycle");

  a_write_lands: assert property (
    wr_take && word_idx == dsl_pkg::IDX_LINK_CTL2 |=>
    link_ctl2_q == $past(AVS_WRITEDATA[7:0]))
    else $error("control write did not land");

  a_read_unmapped: assert property (
    AVS_READ && !AVS_WAITREQUEST && !hit |-> AVS_READDATA == 32'h0)
    else $error("unmapped read not zero");

  a_disable_holds: assert property (
    !link_en |=> !LINK_RESET_N && SERDES_POWER_DOWN && !LINK_CLOCK_ENABLE)
    else $error("disabled link not held off");

  a_decim_twos: assert property (
    dec_sel >= dsl_pkg::DEC_BY4 && dec_sel <= dsl_pkg::DEC_BY32 |=>
    SAMPLE_TWOS_COMPLEMENT && DDC_ENABLE)
    else $error("decimating mode not two's complement");

  a_bypass_format: assert property (
    dec_sel == dsl_pkg::DEC_BYPASS |=>
    SAMPLE_TWOS_COMPLEMENT == $past(ddc_ctrl_q[dsl_pkg::DDC_FMT_BIT])
    && DECIMATION_FACTOR == 6'h01)
    else $error("bypass format wrong");

  a_decim_32: assert property (
    dec_sel == dsl_pkg::DEC_BY32 |=> DECIMATION_FACTOR == 6'h20)
    else $error("decimate code 7 not by 32");

  a_frames_count: assert property (
    1'b1 |=> FRAMES_PER_MULTIFRAME == {1'b0, $past(k_minus_1)} + 6'h01)
    else $error("frames per multiframe wrong");

  a_sync_pick: assert property (
    ARST_N |=> SYNC_REQUEST_N == ($past(link_ctl2_q[dsl_pkg::CTL2_SYNC_BIT])
    ? $past(SYNC_DIFF_N) : $past(SYNC_SE_N)))
    else $error("wrong sync input routed");

  a_id_slot: assert property (
    LINK_DID_INSERT |-> LINK_RESET_N && mf_count_q == dsl_pkg::MF_ID_SLOT)
    else $error("identifier outside second multiframe");

  a_enable_runs: assert property (
    ARST_N && link_en |=>
    LINK_RESET_N && !SERDES_POWER_DOWN && LINK_CLOCK_ENABLE)
    else $error("enabled link not running");

  a_gain_follows: assert property (
    ARST_N |=> FINAL_FILTER_GAIN_BOOST ==
    $past(ddc_ctrl_q[dsl_pkg::DDC_GAIN_BIT]))
    else $error("gain boost not following its bit");

  a_scrambler_follows: assert property (
    ARST_N |=> SCRAMBLER_ENABLE ==
    $past(link_ctl1_q[dsl_pkg::CTL1_SCRM_BIT]))
    else $error("scrambler enable not following its bit");

  a_rate_follows: assert property (
    ARST_N |=> LANE_RATE_DOUBLE ==
    $past(link_ctl1_q[dsl_pkg::CTL1_RATE_BIT]))
    else $error("lane rate not following its bit");

  a_test_follows: assert property (
    ARST_N |=> LINK_TEST_PATTERN ==
    $past(link_ctl2_q[dsl_pkg::CTL2_TEST_LSB +: dsl_pkg::CTL2_TEST_W]))
    else $error("test pattern not following its field");

  a_prbs_flag: assert property (
    LINK_PRBS7_ACTIVE == (LINK_TEST_PATTERN == dsl_pkg::TEST_PRBS7))
    else $error("PRBS7 flag disagrees with test pattern");

  a_reserved_flag: assert property (
    dec_sel == 4'h1 || dec_sel > dsl_pkg::DEC_BY32 |=>
    DECIMATION_RESERVED && !DDC_ENABLE && DECIMATION_FACTOR == 6'h01)
    else $error("reserved decimation code not parked");

  a_lane_skip: assert property (
    AVS_WRITE && !AVS_WAITREQUEST && !AVS_BYTEENABLE[0] |=>
    $stable({ddc_ctrl_q, link_ctl1_q, link_ctl2_q, link_id_q}))
    else $error("write with low byte lane changed a register");

  a_id_follows: assert property (
    ARST_N |=> LINK_DEVICE_IDENTIFIER == $past(link_id_q))
    else $error("identifier output not following register");

  c_ctl1_write: cover property (wr_take && word_idx == dsl_pkg::IDX_LINK_CTL1);
  c_id_read:    cover property (AVS_READ && !AVS_WAITREQUEST
                                && word_idx == dsl_pkg::IDX_LINK_ID);
  c_decimating: cover property (DDC_ENABLE && DECIMATION_FACTOR == 6'h0a);
  c_id_insert:  cover property (LINK_DID_INSERT);
  c_lane_skip:  cover property (AVS_WRITE && !AVS_WAITREQUEST
                                && !AVS_BYTEENABLE[0]);

endmodule

// ===== tb_dsl_config_bank.sv
// Self-checking bench for the down-converter and link configuration bank
// Assumes dsl_pkg and dsl_config_bank compiled first; one 10 MHz clock

`timescale 1ns/100ps

module tb_top;

  // ********************
  // Nets and counters
  // ********************
  logic        clock, arst_n, rd, wr, sync_se_n, sync_diff_n, mf_start;
  logic [11:0] adr;
  logic [31:0] wdat, rdat;
  logic [3:0]  be, test;
  logic        wait_req, link_rst_n, pdn, clk_en, sync_req_n, scram_en, ddr;
  logic        pll, prbs, did_ins, ddc_en, dec_res, twos, gain;
  logic [5:0]  frames, factor;
  logic [7:0]  did;
  int          n_mismatch;
  int          samples_checked;
  // Factor per decimation code; reserved codes fall back to bypass
  localparam logic [5:0] FAC [16] = '{6'h01, 6'h01, 6'h04, 6'h08, 6'h0a,
    6'h10, 6'h14, 6'h20, 6'h01, 6'h01, 6'h01, 6'h01, 6'h01, 6'h01, 6'h01,
    6'h01};

  dsl_config_bank DUT (
    .CLOCK(clock), .ARST_N(arst_n), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be),
    .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_req),
    .SYNC_SE_N(sync_se_n), .SYNC_DIFF_N(sync_diff_n),
    .LINK_MF_START(mf_start), .LINK_RESET_N(link_rst_n),
    .SERDES_POWER_DOWN(pdn), .LINK_CLOCK_ENABLE(clk_en),
    .SYNC_REQUEST_N(sync_req_n), .SCRAMBLER_ENABLE(scram_en),
    .FRAMES_PER_MULTIFRAME(frames), .LANE_RATE_DOUBLE(ddr),
    .FIVE_FOURTHS_PLL_SELECT(pll), .LINK_TEST_PATTERN(test),
    .LINK_PRBS7_ACTIVE(prbs), .LINK_DEVICE_IDENTIFIER(did),
    .LINK_DID_INSERT(did_ins), .DDC_ENABLE(ddc_en),
    .DECIMATION_FACTOR(factor), .DECIMATION_RESERVED(dec_res),
    .SAMPLE_TWOS_COMPLEMENT(twos), .FINAL_FILTER_GAIN_BOOST(gain)
  );

  // ********************
  // Compare and bus tasks
  // ********************
  task automatic check_reg(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_sig(string what, logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Holds the request until waitrequest is seen low, then releases
  task automatic bus(logic is_wr, logic [11:0] a, logic [31:0] d,
                     logic [3:0] b, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    adr <= a;
    wdat <= d;
    be <= b;
    rd <= !is_wr;
    wr <= is_wr;
    do begin
      @(posedge clock);
      n++;
    end while (wait_req !== 1'b0 && n < 20);
    q = rdat;
    if (wait_req !== 1'b0) check_sig("waitrequest", 8'h00, 8'h01);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rdr(logic [11:0] a, logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'h0, q);
    check_reg("register readback", {24'h0, exp}, q);
  endtask

  // Write, read back, then let derived outputs settle
  task automatic wr_rb(logic [9:0] idx, logic [7:0] v);
    logic [31:0] q;
    bus(1'b1, {idx, 2'b00}, {24'hffffff, v}, 4'hf, q);
    rdr({idx, 2'b00}, v);
    @(negedge clock);
  endtask

  task automatic mf_pulse(logic exp);
    @(posedge clock);
    mf_start <= 1'b1;
    @(posedge clock);
    mf_start <= 1'b0;
    @(negedge clock);
    check_sig("identifier slot", {7'h0, exp}, did_ins);
  endtask

  task automatic check_reset();
    rdr({dsl_pkg::IDX_DDC_CTRL, 2'b00}, dsl_pkg::RST_DDC_CTRL);
    rdr({dsl_pkg::IDX_LINK_CTL1, 2'b00}, dsl_pkg::RST_LINK_CTL1);
    rdr({dsl_pkg::IDX_LINK_CTL2, 2'b00}, dsl_pkg::RST_LINK_CTL2);
    rdr({dsl_pkg::IDX_LINK_ID, 2'b00}, dsl_pkg::RST_LINK_ID);
    @(negedge clock);
    check_sig("link reset_n", 8'h01, link_rst_n);
    check_sig("power down", 8'h00, pdn);
    check_sig("frames", 8'h04, frames);
    check_sig("rate double", 8'h01, ddr);
    check_sig("gain boost", 8'h01, gain);
    check_sig("twos", 8'h00, twos);
    check_sig("scrambler", 8'h00, scram_en);
    check_sig("clock enable", 8'h01, clk_en);
    check_sig("factor", 8'h01, factor);
  endtask

  task automatic end_test(string name);
    $display("test %s done", name);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ********************
  // Clock, watchdog, tests
  // ********************
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // The whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    final_report();
  end

  initial begin
    logic [7:0] v;
    logic [3:0] m;
    logic       de;
    logic [31:0] q;
    arst_n = 1'b0;
    adr = 12'h000;
    rd = 1'b0;
    wr = 1'b0;
    wdat = 32'h0;
    be = 4'h0;
    sync_se_n = 1'b1;
    sync_diff_n = 1'b1;
    mf_start = 1'b0;
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    check_reset();
    end_test("reset values");
    // Link held off while other fields change
    wr_rb(dsl_pkg::IDX_LINK_CTL1, 8'h0e);
    check_sig("link reset_n", 8'h00, link_rst_n);
    check_sig("power down", 8'h01, pdn);
    check_sig("clock enable", 8'h00, clk_en);
    for (int c = 0; c < 32; c++) begin
      m = c[3:0];
      v = {c[1:0], c[4], c[0], m};
      de = (m >= 4'h2 && m <= 4'h7);
      wr_rb(dsl_pkg::IDX_DDC_CTRL, v);
      check_sig("factor", {2'b00, FAC[m]}, factor);
      check_sig("ddc enable", {7'h0, de}, ddc_en);
      check_sig("reserved code", {7'h0, m == 4'h1 || m >= 4'h8}, dec_res);
      check_sig("twos", {7'h0, de | c[4]}, twos);
      check_sig("gain boost", {7'h0, c[0]}, gain);
    end
    end_test("decimation");
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'h80 : (i == 1) ? 8'h7e : (i == 2) ? 8'h02 : 8'hfc;
      wr_rb(dsl_pkg::IDX_LINK_CTL1, v);
      check_sig("scrambler", {7'h0, v[7]}, scram_en);
      check_sig("frames", {3'h0, v[6:2]} + 8'h01, frames);
      check_sig("rate double", {7'h0, v[1]}, ddr);
    end
    end_test("link control first");
    for (int t = 0; t < 16; t++) begin
      @(posedge clock);
      sync_se_n <= t[2];
      sync_diff_n <= !t[2];
      v = {t[0], t[1], t[1:0], t[3:0]};
      wr_rb(dsl_pkg::IDX_LINK_CTL2, v);
      check_sig("test pattern", {4'h0, v[3:0]}, test);
      check_sig("prbs7", {7'h0, t == 1}, prbs);
      check_sig("pll select", {7'h0, v[7]}, pll);
      check_sig("sync", {7'h0, v[6] ? !t[2] : t[2]}, sync_req_n);
    end
    end_test("link control second");
    wr_rb(dsl_pkg::IDX_LINK_ID, 8'ha5);
    check_sig("identifier", 8'ha5, did);
    bus(1'b1, 12'h80c, 32'h3c, 4'he, q);
    rdr(12'h80f, 8'ha5);
    bus(1'b1, 12'h810, 32'h5a, 4'hf, q);
    rdr(12'h810, 8'h00);
    wr_rb(dsl_pkg::IDX_LINK_CTL1, 8'h0f);
    check_sig("link reset_n", 8'h01, link_rst_n);
    mf_pulse(1'b0);
    mf_pulse(1'b1);
    mf_pulse(1'b0);
    mf_pulse(1'b0);
    wr_rb(dsl_pkg::IDX_LINK_CTL1, 8'h0e);
    mf_pulse(1'b0);
    wr_rb(dsl_pkg::IDX_LINK_CTL1, 8'h0f);
    check_sig("clock enable", 8'h01, clk_en);
    check_sig("power down", 8'h00, pdn);
    mf_pulse(1'b0);
    mf_pulse(1'b1);
    end_test("identifier and bus");
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    check_reset();
    end_test("second reset");
    final_report();
  end

endmodule
